// [design/ingress_rate_limiter.v]
// Purpose: ingress rate limit registers and metering for switch ports 2 and 3
// Assumes: APB slave, zero wait states; one frame verdict request per cycle at most
// Notes: register byte address is four times the word index
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "irl_consts.vh"
module ingress_rate_limiter #(
    parameter integer REFRESH_CYCLES = `IRL_REFRESH_CYCLES
) (
    // clock and reset
    input wire mclk_i,
    input wire arst_n_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire pready_o,
    output reg pslverr_o,
    output reg [31:0] prdata_o,
    // frame verdict request
    input wire frame_valid_i,
    input wire frame_port_i,
    input wire [1:0] frame_prio_i,
    input wire [10:0] frame_len_i,
    input wire frame_bcast_i,
    input wire frame_mcast_i,
    input wire frame_flood_i,
    // frame verdict
    output reg frame_done_o,
    output reg frame_drop_o,
    // flow control request per port, bit 0 port 2, bit 1 port 3
    output reg [1:0] flow_ctrl_o
);
    localparam [1:0] KIND_CFG = 2'h0;
    localparam [1:0] KIND_LIM = 2'h1;
    localparam [1:0] KIND_STAT = 2'h2;
    localparam [31:0] REFRESH_LAST = REFRESH_CYCLES - 1;

    reg [6:0] cfg_r [0:1];
    reg [6:0] lim_r [0:7];
    reg [1:0] en_r;
    reg [16:0] refresh_cnt_r;
    reg refresh_r;
    wire [5:0] dec;
    wire hit;
    wire dport;
    wire [1:0] dkind;
    wire [1:0] dprio;
    wire setup;
    wire wr;
    wire [6:0] sel_cfg;
    wire counted;
    wire [14:0] cost;
    wire [1:0] drop;
    wire [3:0] over2;
    wire [3:0] over3;
    reg [31:0] rd_nxt;
    integer i;

    // word index to {hit, port, kind, prio}
    function [5:0] decode;
        input [7:0] idx;
        begin
            case (idx)
                `IRL_IDX_P2_CFG: decode = {1'b1, 1'b0, KIND_CFG, 2'h0};
                `IRL_IDX_P2_PRIO0: decode = {1'b1, 1'b0, KIND_LIM, 2'h0};
                `IRL_IDX_P2_PRIO1: decode = {1'b1, 1'b0, KIND_LIM, 2'h1};
                `IRL_IDX_P2_PRIO2: decode = {1'b1, 1'b0, KIND_LIM, 2'h2};
                `IRL_IDX_P2_PRIO3: decode = {1'b1, 1'b0, KIND_LIM, 2'h3};
                `IRL_IDX_P3_CFG: decode = {1'b1, 1'b1, KIND_CFG, 2'h0};
                `IRL_IDX_P3_PRIO0: decode = {1'b1, 1'b1, KIND_LIM, 2'h0};
                `IRL_IDX_P3_PRIO1: decode = {1'b1, 1'b1, KIND_LIM, 2'h1};
                `IRL_IDX_P3_PRIO2: decode = {1'b1, 1'b1, KIND_LIM, 2'h2};
                `IRL_IDX_P3_PRIO3: decode = {1'b1, 1'b1, KIND_LIM, 2'h3};
                `IRL_IDX_STATUS: decode = {1'b1, 1'b0, KIND_STAT, 2'h0};
                default: decode = 6'h00;
            endcase
        end
    endfunction

    // flat limit vector of one port, priority 0 in the low bits
    function [27:0] limits_of;
        input [6:0] l0;
        input [6:0] l1;
        input [6:0] l2;
        input [6:0] l3;
        begin
            limits_of = {l3, l2, l1, l0};
        end
    endfunction

    assign dec = decode(paddr_i[9:2]);
    assign hit = dec[5] & (paddr_i[11:10] == 2'h0) & (paddr_i[1:0] == 2'h0);
    assign dport = dec[4];
    assign dkind = dec[3:2];
    assign dprio = dec[1:0];
    assign setup = psel_i & ~penable_i;
    assign wr = psel_i & penable_i & pwrite_i & hit;
    assign pready_o = 1'b1;

    // register writes
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_r[0] <= `IRL_CFG_RST; // R01 R02 R03 R08 R09
            cfg_r[1] <= `IRL_CFG_RST;
            for (i = 0; i < 8; i = i + 1) begin
                lim_r[i] <= `IRL_LIM_RST; // R04 R05
            end
            en_r <= {2{`IRL_EN_RST}}; // R06
        end else if (wr) begin
            if (dkind == KIND_CFG) begin
                cfg_r[dport] <= pwdata_i[6:0]; // R01 R02 R03 R08 R09
            end else if (dkind == KIND_LIM) begin
                lim_r[{dport, dprio}] <= pwdata_i[6:0]; // R04 R05
                if (dprio == 2'h3) begin
                    en_r[dport] <= pwdata_i[`IRL_LIM_ENABLE]; // R06 R07
                end
            end
        end
    end

    // read data, taken in the setup cycle and held through the access
    always @* begin
        rd_nxt = 32'h00000000;
        case (dkind)
            KIND_CFG: rd_nxt = {25'h0000000, cfg_r[dport]};
            KIND_LIM: begin
                rd_nxt = {25'h0000000, lim_r[{dport, dprio}]}; // R04
                if (dprio == 2'h3) begin
                    rd_nxt[`IRL_LIM_ENABLE] = en_r[dport]; // R06
                end
            end
            KIND_STAT: rd_nxt = {22'h000000, flow_ctrl_o, over3, over2};
            default: rd_nxt = 32'h00000000;
        endcase
        if (!hit) begin
            rd_nxt = 32'h00000000;
        end
    end

    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_o <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else if (setup) begin
            prdata_o <= pwrite_i ? 32'h00000000 : rd_nxt;
            pslverr_o <= ~hit;
        end
    end

    // metering window
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            refresh_cnt_r <= 17'h00000;
            refresh_r <= 1'b0;
        end else if ({15'h0000, refresh_cnt_r} >= REFRESH_LAST) begin
            refresh_cnt_r <= 17'h00000;
            refresh_r <= 1'b1;
        end else begin
            refresh_cnt_r <= refresh_cnt_r + 17'h00001;
            refresh_r <= 1'b0;
        end
    end

    assign sel_cfg = cfg_r[frame_port_i];

    irl_class_filter u_filter (
        .class_sel_i(sel_cfg[`IRL_CFG_CLASS_HI:`IRL_CFG_CLASS_LO]),
        .gap_en_i(sel_cfg[`IRL_CFG_GAP]),
        .pre_en_i(sel_cfg[`IRL_CFG_PRE]),
        .frame_mode_i(sel_cfg[`IRL_CFG_FRAME_MODE]),
        .len_i(frame_len_i),
        .bcast_i(frame_bcast_i),
        .mcast_i(frame_mcast_i),
        .flood_i(frame_flood_i),
        .counted_o(counted),
        .cost_o(cost)
    );

    irl_meter u_meter_p2 (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .refresh_i(refresh_r),
        .port_based_i(cfg_r[0][`IRL_CFG_PORT_BASED]),
        .frame_mode_i(cfg_r[0][`IRL_CFG_FRAME_MODE]),
        .enable_i(en_r[0]),
        .limits_i(limits_of(lim_r[0], lim_r[1], lim_r[2], lim_r[3])),
        .frame_i(frame_valid_i & ~frame_port_i),
        .prio_i(frame_prio_i),
        .counted_i(counted),
        .cost_i(cost),
        .drop_o(drop[0]),
        .over_o(over2)
    );

    irl_meter u_meter_p3 (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .refresh_i(refresh_r),
        .port_based_i(cfg_r[1][`IRL_CFG_PORT_BASED]),
        .frame_mode_i(cfg_r[1][`IRL_CFG_FRAME_MODE]),
        .enable_i(en_r[1]),
        .limits_i(limits_of(lim_r[4], lim_r[5], lim_r[6], lim_r[7])),
        .frame_i(frame_valid_i & frame_port_i),
        .prio_i(frame_prio_i),
        .counted_i(counted),
        .cost_i(cost),
        .drop_o(drop[1]),
        .over_o(over3)
    );

    // verdict and flow control
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            frame_done_o <= 1'b0;
            frame_drop_o <= 1'b0;
            flow_ctrl_o <= 2'h0;
        end else begin
            frame_done_o <= frame_valid_i;
            frame_drop_o <= frame_valid_i & (frame_port_i ? drop[1] : drop[0]); // R10
            flow_ctrl_o[0] <= cfg_r[0][`IRL_CFG_FLOW_EN] & (|over2);
            flow_ctrl_o[1] <= cfg_r[1][`IRL_CFG_FLOW_EN] & (|over3);
        end
    end
endmodule
`default_nettype wire

// [design/irl_class_filter.v]
// Purpose: decide whether a frame is counted and compute its cost
// Assumes: frame length in bytes without preamble and gap
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "irl_consts.vh"
module irl_class_filter (
    // configuration
    input wire [1:0] class_sel_i,
    input wire gap_en_i,
    input wire pre_en_i,
    input wire frame_mode_i,
    // frame description
    input wire [10:0] len_i,
    input wire bcast_i,
    input wire mcast_i,
    input wire flood_i,
    // result
    output reg counted_o,
    output reg [14:0] cost_o
);
    reg [11:0] bytes;

    always @* begin
        case (class_sel_i)
            `IRL_CLASS_ALL: counted_o = 1'b1; // R01
            `IRL_CLASS_BMF: counted_o = bcast_i | mcast_i | flood_i; // R01
            `IRL_CLASS_BM: counted_o = bcast_i | mcast_i; // R01
            `IRL_CLASS_B: counted_o = bcast_i; // R01
            default: counted_o = 1'b1;
        endcase
    end

    always @* begin
        bytes = {1'b0, len_i};
        if (gap_en_i) begin
            bytes = bytes + `IRL_GAP_BYTES; // R02
        end
        if (pre_en_i) begin
            bytes = bytes + `IRL_PRE_BYTES; // R03
        end
        if (frame_mode_i) begin
            cost_o = 15'h0001; // R09
        end else begin
            cost_o = {bytes, 3'h0}; // R09
        end
    end
endmodule
`default_nettype wire

// [design/irl_consts.vh]
// Purpose: constants of the ingress rate limiter (offsets, fields, resets, timing)
// Assumes: included by bare name from design files; definitions only
// Notes: register offsets are word indexes, byte address is four times the index
//
// Notes on behaviour
// (R01) two-bit class selector picks counted frames: all, b/m/flood, b/m, broadcast; reset 00
// (R02) gap bit adds twelve bytes per frame to rate calculations; reset zero
// (R03) preamble bit adds eight bytes per frame to rate calculations; reset zero
// (R04) priority 0 limit is 7 bits [6:0] per port, reset zero, bit 7 reads zero
// (R05) priority 1 and 2 limits are separate 7-bit fields, each reset zero
// (R06) bit 7 of priority 3 register validates the port's limit settings; reset zero
// (R07) software writes all four limit fields first, then sets the enable bit last
// (R08) select bit: set means port-based limiting, clear means per-priority; reset zero
// (R09) unit bit: set counts frames, clear counts bits; reset zero
// (R10) with the enable bit clear no limiting is applied on that port
`ifndef IRL_CONSTS_VH
`define IRL_CONSTS_VH

// word indexes of the registers
`define IRL_IDX_P2_CFG 8'hc6
`define IRL_IDX_P2_PRIO0 8'hc7
`define IRL_IDX_P2_PRIO1 8'hc8
`define IRL_IDX_P2_PRIO2 8'hc9
`define IRL_IDX_P2_PRIO3 8'hca
`define IRL_IDX_P3_CFG 8'hd6
`define IRL_IDX_P3_PRIO0 8'hd7
`define IRL_IDX_P3_PRIO1 8'hd8
`define IRL_IDX_P3_PRIO2 8'hd9
`define IRL_IDX_P3_PRIO3 8'hda
`define IRL_IDX_STATUS 8'hf0

// configuration register fields and the priority 3 limit enable bit
`define IRL_CFG_PORT_BASED 6
`define IRL_CFG_FRAME_MODE 5
`define IRL_CFG_FLOW_EN 4
`define IRL_CFG_CLASS_HI 3
`define IRL_CFG_CLASS_LO 2
`define IRL_CFG_GAP 1
`define IRL_CFG_PRE 0
`define IRL_LIM_ENABLE 7

// reset values
`define IRL_CFG_RST 7'h00
`define IRL_LIM_RST 7'h00
`define IRL_EN_RST 1'b0

// frame class selector codes
`define IRL_CLASS_ALL 2'h0
`define IRL_CLASS_BMF 2'h1
`define IRL_CLASS_BM 2'h2
`define IRL_CLASS_B 2'h3

// per-frame overhead bytes
`define IRL_GAP_BYTES 12'h00c
`define IRL_PRE_BYTES 12'h008

// metering window and budget scale
`define IRL_REFRESH_US 1000
`define IRL_CLK_MHZ 100
`define IRL_REFRESH_CYCLES (`IRL_REFRESH_US * `IRL_CLK_MHZ)
`define IRL_BITS_PER_UNIT 18'h003e8

`endif

// [design/irl_meter.v]
// Purpose: per-port usage counters and limit check for four priorities
// Assumes: refresh_i pulses once per metering window
// Notes: a limit value of zero means unlimited
`timescale 1ns/10ps
`default_nettype none
`include "irl_consts.vh"
module irl_meter (
    // clock and reset
    input wire mclk_i,
    input wire arst_n_i,
    // window
    input wire refresh_i,
    // configuration
    input wire port_based_i,
    input wire frame_mode_i,
    input wire enable_i,
    input wire [27:0] limits_i,
    // frame
    input wire frame_i,
    input wire [1:0] prio_i,
    input wire counted_i,
    input wire [14:0] cost_i,
    // result
    output wire drop_o,
    output wire [3:0] over_o
);
    reg [17:0] used_r [0:3];
    reg [3:0] over_r;
    wire [1:0] idx;
    wire [6:0] lim;
    wire [17:0] budget;
    wire [18:0] sum;
    wire charge;
    integer i;

    function [17:0] budget_of;
        input [6:0] l;
        input fm;
        begin
            if (fm) begin
                budget_of = {11'h000, l};
            end else begin
                budget_of = {11'h000, l} * `IRL_BITS_PER_UNIT;
            end
        end
    endfunction

    assign idx = port_based_i ? 2'h0 : prio_i; // R08
    assign lim = limits_i[idx*7 +: 7]; // R04 R05
    assign budget = budget_of(lim, frame_mode_i); // R09
    assign sum = {1'b0, used_r[idx]} + {4'h0, cost_i};
    assign drop_o = frame_i & enable_i & counted_i & (lim != 7'h00) & (sum > {1'b0, budget}); // R10 R06
    // usage only builds up while limiting is live; enabling does not clear it, only refresh or reset does
    assign charge = frame_i & enable_i & counted_i & (lim != 7'h00) & ~drop_o & ~refresh_i; // R10
    assign over_o = over_r;

    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (i = 0; i < 4; i = i + 1) begin
                used_r[i] <= 18'h00000;
            end
            over_r <= 4'h0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (refresh_i) begin
                    used_r[i] <= 18'h00000;
                end
            end
            if (charge) begin
                used_r[idx] <= sum[18] ? 18'h3ffff : sum[17:0];
            end
            if (refresh_i) begin
                over_r <= 4'h0;
            end
            if (drop_o) begin
                over_r[idx] <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [dv/ingress_rate_limiter_sva.sv]
// Purpose: checker for register readback and frame verdicts
// Assumes: apb writes land at the access edge
// Notes: keeps a software view of a few registers
`timescale 1ns/10ps
`default_nettype none
module ingress_rate_limiter_sva #(
    parameter integer REFRESH_CYCLES = 100000
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    // frames
    input wire logic frame_valid_i,
    input wire logic frame_port_i,
    input wire logic frame_done_o,
    input wire logic frame_drop_o
);
    logic [6:0] cfg2_r;
    logic [6:0] lim0_r;
    logic [1:0] en_r;
    wire logic ok = (paddr_i[11:10] == 2'h0) && (paddr_i[1:0] == 2'h0);
    wire logic wr = psel_i && penable_i && pwrite_i && ok;
    wire logic rd = psel_i && !penable_i && !pwrite_i && ok;
    wire logic [7:0] ix = paddr_i[9:2];
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg2_r <= 7'h00;
            lim0_r <= 7'h00;
            en_r <= 2'h0;
        end else if (wr) begin
            if (ix == 8'hc6) cfg2_r <= pwdata_i[6:0];
            if (ix == 8'hc7) lim0_r <= pwdata_i[6:0];
            if (ix == 8'hca) en_r[0] <= pwdata_i[7];
            if (ix == 8'hda) en_r[1] <= pwdata_i[7];
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    verdict_next_a: assert property (frame_valid_i |=> frame_done_o)
        else $error("no verdict one cycle after a frame");
    drop_qualified_a: assert property (frame_drop_o |-> frame_done_o)
        else $error("drop without a verdict");
    disabled_no_drop_a: assert property (frame_valid_i && !en_r[frame_port_i] |=> !frame_drop_o)
        else $error("drop while limiting disabled");
    cfg_readback_a: assert property (rd && ix == 8'hc6 |=> prdata_o == {25'h0, cfg2_r})
        else $error("config readback wrong");
    prio0_readback_a: assert property (rd && ix == 8'hc7 |=> prdata_o == {25'h0, lim0_r})
        else $error("priority 0 limit readback wrong");
    p2_enable_a: assert property (rd && ix == 8'hca |=> prdata_o[7] == en_r[0])
        else $error("port 2 enable readback wrong");
    p3_enable_a: assert property (rd && ix == 8'hda |=> prdata_o[7] == en_r[1])
        else $error("port 3 enable readback wrong");
    prio_reserved_a: assert property (rd && (ix == 8'hc8 || ix == 8'hd9) |=> prdata_o[31:7] == 25'h0)
        else $error("reserved bits not zero");
endmodule
bind ingress_rate_limiter ingress_rate_limiter_sva #(.REFRESH_CYCLES(REFRESH_CYCLES)) sva (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .frame_valid_i(frame_valid_i), .frame_port_i(frame_port_i),
    .frame_done_o(frame_done_o), .frame_drop_o(frame_drop_o));
`default_nettype wire

// [dv/ingress_rate_limiter_test.sv]
// Purpose: register and metering tests of the ingress rate limiter
// Assumes: short metering window, the last test waits for the first window refresh and runs in the second window
// Notes: limit 1 means 1000 bits or one frame per window
`timescale 1ns/10ps
`default_nettype none
module ingress_rate_limiter_test;
    localparam integer RC = 2000;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire logic pready, pslverr, done, drop, fv, fp, fb, fm, ff;
    wire logic [31:0] prdata;
    wire logic [1:0] flow, fpr;
    wire logic [10:0] flen;
    int err_total = 0;
    int check_count = 0;
    logic d;
    logic se;
    logic [31:0] r;
    logic [7:0] ix [10] = '{8'hc6, 8'hc7, 8'hc8, 8'hc9, 8'hca, 8'hd6, 8'hd7, 8'hd8, 8'hd9, 8'hda};
    always #5 mclk = ~mclk;
    ingress_rate_limiter #(.REFRESH_CYCLES(RC)) dut (
        .mclk_i(mclk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata),
        .frame_valid_i(fv), .frame_port_i(fp), .frame_prio_i(fpr), .frame_len_i(flen),
        .frame_bcast_i(fb), .frame_mcast_i(fm), .frame_flood_i(ff),
        .frame_done_o(done), .frame_drop_o(drop), .flow_ctrl_o(flow));
    link_partner lp (
        .mclk_i(mclk), .valid_o(fv), .port_o(fp), .prio_o(fpr), .len_o(flen),
        .bc_o(fb), .mc_o(fm), .fl_o(ff), .done_i(done), .drop_i(drop));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'h0, a, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        r = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            err_total++;
            $display("Error %0t: bus timeout", $time);
            tally_and_finish();
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        chk(r, e);
    endtask
    task automatic fr(input logic p, input logic [1:0] pr, input logic [10:0] l, input logic [1:0] t,
                      input logic e);
        lp.send(p, pr, l, t, d);
        chk({31'h0, d}, {31'h0, e});
    endtask
    initial begin
        int n;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rchk(ix[i], 32'h0);
            apb(1'b1, ix[i], 8'hff);
            rchk(ix[i], (i % 5 == 4) ? 32'hff : 32'h7f);
            apb(1'b1, ix[i], 8'h00);
        end
        rchk(8'h10, 32'h0);
        chk({31'h0, se}, 32'h1);
        apb(1'b1, 8'hc7, 8'h01);
        fr(1'b0, 2'h0, 11'd1000, 2'h0, 1'b0);
        apb(1'b1, 8'hca, 8'h80);
        fr(1'b0, 2'h0, 11'd1000, 2'h0, 1'b1);
        apb(1'b1, 8'hc6, 8'h12);
        fr(1'b0, 2'h0, 11'd114, 2'h0, 1'b1);
        apb(1'b1, 8'hc6, 8'h11);
        fr(1'b0, 2'h0, 11'd118, 2'h0, 1'b1);
        apb(1'b1, 8'hc6, 8'h10);
        fr(1'b0, 2'h0, 11'd118, 2'h0, 1'b0);
        fr(1'b0, 2'h0, 11'd7, 2'h0, 1'b0);
        fr(1'b0, 2'h0, 11'd1, 2'h0, 1'b1);
        @(posedge mclk);
        #1;
        chk({30'h0, flow}, 32'h1);
        rchk(8'hf0, 32'h101);
        apb(1'b1, 8'hd8, 8'h01);
        apb(1'b1, 8'hda, 8'h80);
        apb(1'b1, 8'hd6, 8'h20);
        fr(1'b1, 2'h1, 11'd1000, 2'h0, 1'b0);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 8'hd6, {4'h2, c[1:0], 2'h0});
            for (int t = 0; t < 4; t++) begin
                fr(1'b1, 2'h1, 11'd64, t[1:0], t >= c);
            end
        end
        apb(1'b1, 8'hd7, 8'h01);
        apb(1'b1, 8'hda, 8'h80);
        apb(1'b1, 8'hd6, 8'h60);
        fr(1'b1, 2'h2, 11'd64, 2'h0, 1'b0);
        fr(1'b1, 2'h2, 11'd64, 2'h0, 1'b1);
        rchk(8'hf0, 32'h131);
        n = 0;
        while (flow[0] !== 1'b0 && n < 2 * RC) begin
            @(posedge mclk);
            n++;
        end
        chk({31'h0, flow[0]}, 32'h0);
        if (n >= 2 * RC) begin
            tally_and_finish();
        end
        fr(1'b0, 2'h0, 11'd118, 2'h0, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// [dv/link_partner.sv]
// Purpose: link partner model that offers frames for a verdict
// Assumes: one frame per call, verdict one cycle after the request
// Notes: fields are scrambled once the request is released
`timescale 1ns/10ps
`default_nettype none
module link_partner (
    // clock
    input wire logic mclk_i,
    // frame request
    output logic valid_o,
    output logic port_o,
    output logic [1:0] prio_o,
    output logic [10:0] len_o,
    output logic bc_o,
    output logic mc_o,
    output logic fl_o,
    // verdict
    input wire logic done_i,
    input wire logic drop_i
);
    initial begin
        {valid_o, port_o, prio_o, len_o, bc_o, mc_o, fl_o} = '0;
    end
    // t: 0 unicast, 1 flooded unicast, 2 multicast, 3 broadcast
    task automatic send(input logic p, input logic [1:0] pr, input logic [10:0] l, input logic [1:0] t,
                        output logic d);
        @(posedge mclk_i);
        valid_o <= 1'b1;
        {port_o, prio_o, len_o} <= {p, pr, l};
        {bc_o, mc_o, fl_o} <= {t == 2'h3, t == 2'h2, t == 2'h1};
        @(posedge mclk_i);
        valid_o <= 1'b0;
        {port_o, prio_o, len_o} <= ~{p, pr, l};
        {bc_o, mc_o, fl_o} <= ~{t == 2'h3, t == 2'h2, t == 2'h1};
        #1;
        d = done_i ? drop_i : 1'bx;
    endtask
endmodule
`default_nettype wire
